// File: hw/bcdrtc_top.sv
// Purpose: bcd calendar clock with hold, adjust and regulation on axi4-lite
// Assumes: oscillator pin is asynchronous; one write and one read at a time
// Notes: alarm flag is readable and cleared by writing 1
// Operation
// [R1] runs only with low-speed oscillator enabled
// [R2] software keeps oscillator on during sleep
// [R3] seven-bit signed correction, -64 to +63
// [R4] software computes correction from ppm tolerance
// [R5] software rewrites correction every period
// [R6] regulation touches only divider and time
// [R7] correction applied when divider reaches 0x7f
// [R8] monitor pin shows second, starts low
// [R9] software selects clock function on port
// [R10] software waits for busy clear before setting
// [R11] bcd field widths per unit
// [R12] am/pm only active in 12-hour mode
// [R13] software adjusts, clears flags, enables interrupts
// [R14] software holds, reads, releases for coherence
// [R15] missed seconds in hold give one second
// [R16] software programs alarm within a day
// [R17] alarm raised on time field match
// [R18] counters advance on each second
// [R19] leap years divisible by four, except 00
// [R20] out-of-range values corrected at count-up
// [R21] thirty-second adjust rounds to nearest minute; at minute 59 with seconds 30 to 58 the code zeroes minutes, hour kept
// [R22] busy flag high 1/256 s per count-up
// [R23] regulation busy from write until applied
// [R24] carries ripple seconds to year, weekday wraps
// [R25] signed correction added to divider once
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module bcdrtc_top
   import bcdrtc_pkg::*;
#(
   parameter int OSC_PER_STEP = 128 // oscillator cycles per 1/256 s
) (
   input wire logic I_CLK_SYS,          // 250 mhz system clock
   input wire logic I_NRST,             // sync reset, active low
   input wire logic I_OSC_LS,           // 32.768 khz oscillator level
   input wire logic [7:0] I_AWADDR,     // write address
   input wire logic I_AWVALID,          // write address valid
   output logic O_AWREADY,              // write address ready
   input wire logic [31:0] I_WDATA,     // write data
   input wire logic [3:0] I_WSTRB,      // write strobes
   input wire logic I_WVALID,           // write data valid
   output logic O_WREADY,               // write data ready
   output logic [1:0] O_BRESP,          // write response
   output logic O_BVALID,               // write response valid
   input wire logic I_BREADY,           // write response ready
   input wire logic [7:0] I_ARADDR,     // read address
   input wire logic I_ARVALID,          // read address valid
   output logic O_ARREADY,              // read address ready
   output logic [31:0] O_RDATA,         // read data
   output logic [1:0] O_RRESP,          // read response
   output logic O_RVALID,               // read valid
   input wire logic I_RREADY,           // read ready
   output logic O_ONE_SECOND_MONITOR_OUT // 1 hz monitor pin
);
   typedef struct packed {
      logic [1:0] osc_sync;
      logic osc_prev;
      logic osc_en;
      logic mon_en;
      logic run;
      logic h24;
      logic hold;
      logic missed;
      logic cbusy;
      logic rbusy;
      logic alarm_flag;
      logic mon;
      bcdrtc_time_t tm;
      logic [22:0] alm;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bcdrtc_state_t;

   bcdrtc_state_t s_q, s_d;
   bcdrtc_tick_if tk ();
   bcdrtc_time_t tm_next;
   logic wr_fire, rd_fire, osc_edge, step, alarm_hit;
   logic [31:0] wd, rd_word;
   logic [1:0] rd_resp;

   ////////////////////////////////////////////////////////////////////////////
   // divider and calendar step
   bcdrtc_div #(.OSC_PER_STEP(OSC_PER_STEP)) u_div (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_osc_edge(osc_edge),
      .i_run(s_q.osc_en && s_q.run), // [R1]
      .tk(tk)
   );

   bcdrtc_cal u_cal (
      .i_t(s_q.tm),
      .i_h24(s_q.h24),
      .o_t(tm_next)
   );

   // edge of the synchronised oscillator; only stage two is looked at
   assign osc_edge = s_q.osc_sync[1] && !s_q.osc_prev;
   assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign rd_fire = I_ARVALID && !s_q.rvalid;
   // write data used as received; strobes gate only the control register fields
   assign wd = s_q.wdata;

   // alarm compares seconds, minutes, hours and am/pm in 12-hour mode
   assign alarm_hit = {s_q.tm.sec_t10, s_q.tm.sec_u} == s_q.alm[6:0]
      && {s_q.tm.min_t10, s_q.tm.min_u} == s_q.alm[13:7]
      && {s_q.tm.hr_t10, s_q.tm.hr_u} == s_q.alm[19:14]
      && (s_q.h24 || s_q.tm.pm == s_q.alm[20]); // [R17] [R12]

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_resp = RESP_OKAY;
      case (I_ARADDR)
         ADDR_CTRL: begin
            rd_word[CTRL_RUN] = s_q.run;
            rd_word[CTRL_24H] = s_q.h24;
            rd_word[CTRL_HOLD] = s_q.hold;
            rd_word[CTRL_CBUSY] = s_q.cbusy; // [R22]
            rd_word[CTRL_RBUSY] = s_q.rbusy; // [R23]
            rd_word[CTRL_OSCEN] = s_q.osc_en;
            rd_word[CTRL_MONEN] = s_q.mon_en;
         end
         ADDR_SEC: rd_word[6:0] = {s_q.tm.sec_t10, s_q.tm.sec_u};
         ADDR_MINHR: begin
            rd_word[6:0] = {s_q.tm.min_t10, s_q.tm.min_u};
            rd_word[13:8] = {s_q.tm.hr_t10, s_q.tm.hr_u};
            rd_word[MH_AMPM] = s_q.tm.pm;
         end
         ADDR_DAYMON: rd_word[12:0] = {s_q.tm.mon_t10, s_q.tm.mon_u, 2'b00,
            s_q.tm.day_t10, s_q.tm.day_u};
         ADDR_YRWK: rd_word[10:0] = {s_q.tm.wk, s_q.tm.yr_t10, s_q.tm.yr_u};
         ADDR_ALMSEC: rd_word[6:0] = s_q.alm[6:0];
         ADDR_ALMMH: rd_word[14:0] = {s_q.alm[20], s_q.alm[19:14], 1'b0, s_q.alm[13:7]};
         ADDR_STAT: rd_word[STAT_ALARM] = s_q.alarm_flag;
         default: rd_resp = RESP_SLVERR;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state: bus, control, counting
   always_comb begin
      s_d = s_q;
      s_d.osc_sync = {s_q.osc_sync[0], I_OSC_LS};
      s_d.osc_prev = s_q.osc_sync[1];
      step = 1'b0;
      tk.trim_load = 1'b0;
      tk.trim_val = wd[CTRL_TRM_LSB +: 7]; // [R3]
      // bus handshakes
      if (I_AWVALID && !s_q.aw_got) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = I_AWADDR;
      end
      if (I_WVALID && !s_q.w_got) begin
         s_d.w_got = 1'b1;
         s_d.wdata = I_WDATA;
         s_d.wstrb = I_WSTRB;
      end
      if (s_q.bvalid && I_BREADY) s_d.bvalid = 1'b0;
      if (s_q.rvalid && I_RREADY) s_d.rvalid = 1'b0;
      if (rd_fire) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_word;
         s_d.rresp = rd_resp;
      end
      // busy drops after one 1/256 s step
      if (tk.tick256) s_d.cbusy = 1'b0;
      if (tk.trim_done) s_d.rbusy = 1'b0; // [R23]
      // second count-up or deferred +1 after hold release
      if (tk.sec_pulse) begin
         if (s_q.hold) s_d.missed = 1'b1; // [R15]
         else step = 1'b1;
      end else if (!s_q.hold && s_q.missed) begin
         step = 1'b1; // [R15]
         s_d.missed = 1'b0;
      end
      if (step) begin
         s_d.tm = tm_next; // [R18]
         s_d.cbusy = 1'b1; // [R22]
      end
      if (tk.sec_pulse || tk.trim_done) s_d.mon = 1'b0;
      if (s_q.mon_en) s_d.mon = tk.half_level; // [R8]
      else s_d.mon = 1'b0; // [R8]
      // register writes
      if (wr_fire) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         case (s_q.awaddr)
            ADDR_CTRL: begin
               if (s_q.wstrb[0]) begin
                  s_d.run = wd[CTRL_RUN];
                  s_d.h24 = wd[CTRL_24H];
                  s_d.hold = wd[CTRL_HOLD] && !s_q.rbusy;
                  if (wd[CTRL_ADJ]) begin
                     s_d.cbusy = 1'b1; // [R22]
                     if ({s_q.tm.sec_t10, s_q.tm.sec_u} >= 7'h30) begin
                        s_d.tm = tm_next; // [R21]
                        s_d.tm.sec_t10 = 3'h0;
                        s_d.tm.sec_u = 4'h0;
                        s_d.tm.min_t10 = s_q.tm.min_t10;
                        s_d.tm.min_u = s_q.tm.min_u;
                        if ({s_q.tm.min_t10, s_q.tm.min_u} == 7'h59) begin
                           s_d.tm = u_min_wrap(s_q.tm, tm_next);
                        end else if (s_q.tm.min_u == 4'h9) begin
                           s_d.tm = s_q.tm;
                           s_d.tm.min_u = 4'h0;
                           s_d.tm.min_t10 = s_q.tm.min_t10 + 3'h1;
                        end else begin
                           s_d.tm = s_q.tm;
                           s_d.tm.min_u = s_q.tm.min_u + 4'h1;
                        end
                        s_d.tm.sec_t10 = 3'h0;
                        s_d.tm.sec_u = 4'h0;
                     end else begin
                        s_d.tm.sec_t10 = 3'h0; // [R21]
                        s_d.tm.sec_u = 4'h0;
                     end
                  end
               end
               if (s_q.wstrb[1] && !s_q.rbusy) begin
                  tk.trim_load = 1'b1; // [R25]
                  s_d.rbusy = 1'b1; // [R23]
               end
               if (s_q.wstrb[2]) begin
                  s_d.osc_en = wd[CTRL_OSCEN];
                  s_d.mon_en = wd[CTRL_MONEN];
               end
            end
            ADDR_SEC: {s_d.tm.sec_t10, s_d.tm.sec_u} = wd[6:0];
            ADDR_MINHR: begin
               {s_d.tm.min_t10, s_d.tm.min_u} = wd[6:0];
               {s_d.tm.hr_t10, s_d.tm.hr_u} = wd[MH_HOUR_LSB +: 6];
               s_d.tm.pm = wd[MH_AMPM];
            end
            ADDR_DAYMON: begin
               {s_d.tm.day_t10, s_d.tm.day_u} = wd[5:0];
               {s_d.tm.mon_t10, s_d.tm.mon_u} = wd[12:8];
            end
            ADDR_YRWK: {s_d.tm.wk, s_d.tm.yr_t10, s_d.tm.yr_u} = wd[10:0];
            ADDR_ALMSEC: s_d.alm[6:0] = wd[6:0];
            ADDR_ALMMH: s_d.alm[20:7] = {wd[14], wd[13:8], wd[6:0]};
            ADDR_STAT: if (wd[STAT_ALARM]) s_d.alarm_flag = 1'b0;
            default: s_d.bresp = RESP_SLVERR;
         endcase
      end
      // alarm set beats the software clear in the same cycle
      if (s_q.cbusy && tk.tick256 && alarm_hit) s_d.alarm_flag = 1'b1; // [R17]
   end

   // minute rollover on adjust: next-second image when seconds are 59, else current image with minutes cleared
   function automatic bcdrtc_time_t u_min_wrap(input bcdrtc_time_t cur,
      input bcdrtc_time_t nx);
      bcdrtc_time_t r;
      r = nx;
      if (cur.sec_t10 != 3'h5 || cur.sec_u != 4'h9) begin
         r = cur;
         r.min_t10 = 3'h0;
         r.min_u = 4'h0;
      end
      return r;
   endfunction : u_min_wrap

   // state register
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign O_AWREADY = !s_q.aw_got;
   assign O_WREADY = !s_q.w_got;
   assign O_BVALID = s_q.bvalid;
   assign O_BRESP = s_q.bresp;
   assign O_ARREADY = !s_q.rvalid;
   assign O_RVALID = s_q.rvalid;
   assign O_RDATA = s_q.rdata;
   assign O_RRESP = s_q.rresp;
   assign O_ONE_SECOND_MONITOR_OUT = s_q.mon;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence busy_rise_s;
      !s_q.cbusy ##1 s_q.cbusy;
   endsequence

   hold_freeze_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R15]
      (s_q.hold && !wr_fire) |=> $stable(s_q.tm.sec_u) || $past(wr_fire))
      else $error("time moved during hold");
   catch_up_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R15]
      (s_q.missed && !s_q.hold && !tk.sec_pulse) |=> s_q.cbusy && !s_q.missed)
      else $error("no single catch-up after hold");
   busy_end_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R22]
      (s_q.cbusy && tk.tick256 && !step && !wr_fire) |=> !s_q.cbusy)
      else $error("busy held past one step");
   busy_cause_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R22]
      busy_rise_s |-> $past(step || wr_fire))
      else $error("busy rose without a count-up");
   alarm_set_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R17]
      (s_q.cbusy && tk.tick256 && alarm_hit) |=> s_q.alarm_flag)
      else $error("alarm flag not set on match");
   mon_follow_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R8]
      s_q.mon_en |=> O_ONE_SECOND_MONITOR_OUT == $past(tk.half_level))
      else $error("monitor does not follow the divider");
   hold_refuse_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R23]
      (wr_fire && s_q.awaddr == ADDR_CTRL && s_q.rbusy && !s_q.hold) |=> !s_q.hold)
      else $error("hold taken while regulating");
   rbusy_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R23]
      tk.trim_done |=> !s_q.rbusy)
      else $error("regulation busy stuck after trim");
   mon_off_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R8]
      !s_q.mon_en |=> !O_ONE_SECOND_MONITOR_OUT)
      else $error("monitor driven while disabled");
   rbusy_set_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R23]
      tk.trim_load |=> s_q.rbusy)
      else $error("regulation busy not set");
   stop_osc_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R1]
      (!s_q.osc_en && !wr_fire && !s_q.missed && !tk.sec_pulse) |=> $stable(s_q.tm))
      else $error("clock ran without oscillator");
   sec_range_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST) // [R18]
      (step && s_q.tm.sec_u < 4'h9 && s_q.tm.sec_t10 <= 3'h5 && !wr_fire)
      |=> s_q.tm.sec_u == $past(s_q.tm.sec_u) + 4'h1)
      else $error("second did not advance");
   resp_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
      wr_fire |=> O_BVALID)
      else $error("write response missing");
endmodule : bcdrtc_top
`default_nettype wire

// File: pkg/bcdrtc_pkg.sv
// Purpose: constants and shared types for the bcd calendar clock
// Assumes: 250 MHz system clock, 32.768 kHz oscillator sampled as a level
// Notes: register offsets are byte addresses on the axi4-lite slave
`default_nettype none
package bcdrtc_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SEC = 8'h04;
   localparam logic [7:0] ADDR_MINHR = 8'h08;
   localparam logic [7:0] ADDR_DAYMON = 8'h0C;
   localparam logic [7:0] ADDR_YRWK = 8'h10;
   localparam logic [7:0] ADDR_ALMSEC = 8'h14;
   localparam logic [7:0] ADDR_ALMMH = 8'h18;
   localparam logic [7:0] ADDR_STAT = 8'h1C;
   // control register fields
   localparam int CTRL_RUN = 0;
   localparam int CTRL_ADJ = 2;
   localparam int CTRL_24H = 4;
   localparam int CTRL_HOLD = 5;
   localparam int CTRL_CBUSY = 6;
   localparam int CTRL_TRM_LSB = 8;
   localparam int CTRL_RBUSY = 15;
   localparam int CTRL_OSCEN = 16;
   localparam int CTRL_MONEN = 17;
   // status register fields
   localparam int STAT_ALARM = 0;
   // minute/hour register fields
   localparam int MH_HOUR_LSB = 8;
   localparam int MH_AMPM = 14;
   // divider: 128 steps of 1/256 s per half second
   localparam int DIV_W = 8;
   localparam logic [7:0] DIV_TRIM_POINT = 8'h7F;
   localparam logic [7:0] DIV_TOP = 8'hFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // bcd time and calendar image
   typedef struct packed {
      logic [2:0] sec_t10;
      logic [3:0] sec_u;
      logic [2:0] min_t10;
      logic [3:0] min_u;
      logic [1:0] hr_t10;
      logic [3:0] hr_u;
      logic pm;
      logic [1:0] day_t10;
      logic [3:0] day_u;
      logic mon_t10;
      logic [3:0] mon_u;
      logic [3:0] yr_t10;
      logic [3:0] yr_u;
      logic [2:0] wk;
   } bcdrtc_time_t;
endpackage : bcdrtc_pkg
`default_nettype wire

// File: pkg/bcdrtc_tick_if.sv
// Purpose: carries the 1/256 s tick and second strobes between modules
// Assumes: single clock domain
// Notes: strobes are one-cycle pulses
`default_nettype none
interface bcdrtc_tick_if;
   logic tick256;
   logic sec_pulse;
   logic half_level;
   logic trim_load;
   logic signed [6:0] trim_val;
   logic trim_done;
   modport src (output tick256, output sec_pulse, output half_level, output trim_done,
      input trim_load, input trim_val);
   modport dst (input tick256, input sec_pulse, input half_level, input trim_done,
      output trim_load, output trim_val);
endinterface : bcdrtc_tick_if
`default_nettype wire

// File: hw/bcdrtc_div.sv
// Purpose: 1 hz divider counting 1/256 s steps with regulation trim
// Assumes: osc_edge is a clean one-cycle pulse per oscillator period
// Notes: trim lands when the count moves to 0x7f, once per write
`default_nettype none
module bcdrtc_div
   import bcdrtc_pkg::*;
#(
   parameter int OSC_PER_STEP = 128 // oscillator cycles per 1/256 s
) (
   input wire logic i_clk,       // system clock
   input wire logic i_nrst,      // sync reset, active low
   input wire logic i_osc_edge,  // oscillator rising edge
   input wire logic i_run,       // divider enable
   bcdrtc_tick_if.src tk         // ticks out, trim in
);
   typedef struct packed {
      logic [6:0] pre;
      logic [7:0] cnt;
      logic pend;
      logic signed [6:0] val;
      logic tick;
      logic sec;
      logic done;
   } bcdrtc_div_t;
   bcdrtc_div_t s_q, s_d;
   logic [7:0] nxt;

   ////////////////////////////////////////////////////////////////////////////
   // prescale and count; trim adds the signed value when reaching 0x7f
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.sec = 1'b0;
      s_d.done = 1'b0;
      nxt = s_q.cnt + 8'h01;
      if (tk.trim_load) begin
         s_d.pend = 1'b1;
         s_d.val = tk.trim_val; // [R3]
      end
      if (i_run && i_osc_edge) begin
         if (s_q.pre == 7'(OSC_PER_STEP - 1)) begin
            s_d.pre = 7'h00;
            s_d.tick = 1'b1;
            s_d.cnt = nxt;
            if (nxt == DIV_TRIM_POINT && s_q.pend) begin
               s_d.cnt = nxt + 8'(s_q.val); // [R7] [R25] [R6]
               s_d.pend = 1'b0;
               s_d.done = 1'b1;
            end
            if (s_q.cnt == DIV_TOP) begin
               s_d.sec = 1'b1;
            end
         end else begin
            s_d.pre = s_q.pre + 7'h01;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tk.tick256 = s_q.tick;
   assign tk.sec_pulse = s_q.sec;
   assign tk.half_level = s_q.cnt[7];
   assign tk.trim_done = s_q.done;

   trim_apply_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R7]
      (i_run && i_osc_edge && s_q.pre == 7'(OSC_PER_STEP - 1) && s_q.pend
       && s_q.cnt == 8'h7E) |=> (s_q.cnt == 8'(8'h7F + 8'(s_q.val))) && !s_q.pend)
      else $error("trim not applied at 0x7f");
endmodule : bcdrtc_div
`default_nettype wire

// File: hw/bcdrtc_cal.sv
// Purpose: one-second bcd calendar step with range correction
// Assumes: called combinationally from the top
// Notes: pure function module, no state
`default_nettype none
module bcdrtc_cal
   import bcdrtc_pkg::*;
(
   input wire bcdrtc_time_t i_t,  // current time
   input wire logic i_h24,        // 24-hour mode
   output bcdrtc_time_t o_t       // time plus one second
);
   logic [7:0] sec, mn, hr, dy, mo, yr, dmax;
   always_comb begin
      o_t = i_t;
      sec = {1'b0, i_t.sec_t10, i_t.sec_u};
      mn = {1'b0, i_t.min_t10, i_t.min_u};
      hr = {2'b00, i_t.hr_t10, i_t.hr_u};
      dy = {2'b00, i_t.day_t10, i_t.day_u};
      mo = {3'b000, i_t.mon_t10, i_t.mon_u};
      yr = {i_t.yr_t10, i_t.yr_u};
      // days in month, leap year when divisible by four but not 00
      case (mo)
         8'h02: dmax = (yr != 8'h00 && !yr[4] == !yr[1] && !yr[0]) ? 8'h29 : 8'h28; // [R19]
         8'h04, 8'h06, 8'h09, 8'h11: dmax = 8'h30;
         default: dmax = 8'h31;
      endcase
      if (sec[3:0] < 4'h9 && sec < 8'h59) begin
         sec = sec + 8'h01; // [R18]
      end else if (sec[3:0] == 4'h9 && sec < 8'h59) begin
         sec = sec + 8'h07; // [R18]
      end else begin
         sec = 8'h00; // [R24]
         if (mn[3:0] < 4'h9 && mn < 8'h59) begin
            mn = mn + 8'h01;
         end else if (mn[3:0] == 4'h9 && mn < 8'h59) begin
            mn = mn + 8'h07; // [R24]
         end else begin
            mn = 8'h00;
            if (i_h24) begin
               if (hr == 8'h23 || hr > 8'h23 || hr[3:0] > 4'h9) begin
                  hr = 8'h00; // [R20]
                  if (o_t.wk >= 3'h6) o_t.wk = 3'h0; // [R20] [R24]
                  else o_t.wk = o_t.wk + 3'h1;
               end else if (hr[3:0] == 4'h9) begin
                  hr = hr + 8'h07;
               end else begin
                  hr = hr + 8'h01;
               end
            end else begin
               if (hr == 8'h11) begin
                  hr = 8'h12;
                  o_t.pm = !i_t.pm; // [R12]
               end else if (hr == 8'h12 || hr > 8'h12 || hr == 8'h00 || hr[3:0] > 4'h9) begin
                  hr = 8'h01; // [R20]
               end else if (hr[3:0] == 4'h9) begin
                  hr = hr + 8'h07;
               end else begin
                  hr = hr + 8'h01;
               end
            end
            if ((i_h24 && hr == 8'h00) || (!i_h24 && hr == 8'h12 && i_t.pm)) begin
               if (!i_h24) begin
                  if (o_t.wk >= 3'h6) o_t.wk = 3'h0;
                  else o_t.wk = o_t.wk + 3'h1;
               end
               if (dy >= dmax || dy == 8'h00 || dy[3:0] > 4'h9) begin
                  dy = 8'h01; // [R20]
                  if (mo >= 8'h12 || mo == 8'h00 || mo[3:0] > 4'h9) begin
                     mo = 8'h01;
                     if (yr >= 8'h99 || yr[3:0] > 4'h9 || yr[7:4] > 4'h9) yr = 8'h00;
                     else if (yr[3:0] == 4'h9) yr = yr + 8'h07;
                     else yr = yr + 8'h01;
                  end else if (mo[3:0] == 4'h9) begin
                     mo = 8'h10;
                  end else begin
                     mo = mo + 8'h01;
                  end
               end else if (dy[3:0] == 4'h9) begin
                  dy = dy + 8'h07;
               end else begin
                  dy = dy + 8'h01;
               end
            end
         end
      end
      if (o_t.wk == 3'h7) o_t.wk = 3'h0; // [R20]
      o_t.sec_t10 = sec[6:4]; // [R11]
      o_t.sec_u = sec[3:0];
      o_t.min_t10 = mn[6:4];
      o_t.min_u = mn[3:0];
      o_t.hr_t10 = hr[5:4];
      o_t.hr_u = hr[3:0];
      o_t.day_t10 = dy[5:4];
      o_t.day_u = dy[3:0];
      o_t.mon_t10 = mo[4];
      o_t.mon_u = mo[3:0];
      o_t.yr_t10 = yr[7:4];
      o_t.yr_u = yr[3:0];
   end
endmodule : bcdrtc_cal
`default_nettype wire

// File: dv/bcdrtc_top_test.sv
// Purpose: self-checking bench for the bcd calendar clock
// Assumes: OSC_PER_STEP=1, oscillator edge every 4 clocks
// Notes: a second is 1024 system clocks here
`default_nettype none
module bcdrtc_top_test import bcdrtc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} bcdrtc_row_t;
   localparam logic [31:0] CTL = 32'h00030011; // run, 24h, osc, monitor, 0 ppm
   logic clk = 1'b0, nrst = 1'b0, osc = 1'b0, mon;
   // response readies stay high: every answer is taken at the edge it is seen
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [1:0] bresp, rresp, rs, cnt = 2'h0;
   int n_mismatch = 0, comparisons = 0, i;
   bcdrtc_row_t rows [6] = '{'{ADDR_SEC, 32'h59, 32'h59}, '{ADDR_MINHR, 32'h2359, 32'h2359},
      '{ADDR_DAYMON, 32'h1231, 32'h1231}, '{ADDR_YRWK, 32'h699, 32'h699},
      '{ADDR_ALMSEC, 32'h0, 32'h0}, '{ADDR_ALMMH, 32'h0, 32'h0}};
   bcdrtc_top #(.OSC_PER_STEP(1)) DUT (.I_CLK_SYS(clk), .I_NRST(nrst), .I_OSC_LS(osc),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
      .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
      .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
      .I_RREADY(rready), .O_ONE_SECOND_MONITOR_OUT(mon));
   ////////////////////////////////////////////////////////////////////////////
   // 4 ns clock; oscillator at a quarter of it, far above 32 khz to save time
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cnt <= cnt + 2'h1;
      osc <= cnt[1];
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // a spent bound is a mismatch and ends the run
   task automatic lim(input int n, input int m);
      if (n >= m) begin
         n_mismatch++;
         wrap_up();
      end
   endtask : lim
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         n_mismatch++;
      end
   endtask : chk
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
      end while (!bvalid && n < 60);
      rs = bresp;
      lim(n, 60);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready && arvalid) arvalid <= 1'b0;
      end while (!rvalid && n < 60);
      rv = rdata;
      rs = rresp;
      lim(n, 60);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk({31'h0, mon}, 32'h0);
      rd(ADDR_CTRL);
      chk(rv, 32'h0);
      // time and alarm fields written with the clock stopped
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d);
         rd(rows[k].a);
         chk(rv, rows[k].e);
      end
      wr(8'h20, 32'h1);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      rd(8'h20);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      // last second of a year: everything rolls in one step
      wr(ADDR_CTRL, CTL);
      i = 0;
      do begin
         rd(ADDR_SEC);
         i++;
      end while (rv[6:0] !== 7'h00 && i < 600);
      lim(i, 600);
      rd(ADDR_MINHR);
      chk(rv, 32'h0);
      rd(ADDR_DAYMON);
      chk(rv, 32'h0101);
      rd(ADDR_YRWK);
      chk(rv, 32'h0);
      rd(ADDR_STAT);
      chk(rv, 32'h1);
      wr(ADDR_STAT, 32'h1);
      rd(ADDR_STAT);
      chk(rv, 32'h0);
      // two seconds missed in hold give a single catch-up
      wr(ADDR_CTRL, CTL | 32'h20);
      // monitor must rise in the second half of the held second
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (mon !== 1'b1 && i < 1100);
      lim(i, 1100);
      chk({31'h0, mon}, 32'h1);
      repeat (1600) @(posedge clk);
      rd(ADDR_SEC);
      chk(rv, 32'h0);
      wr(ADDR_CTRL, CTL);
      repeat (20) @(posedge clk);
      rd(ADDR_SEC);
      chk(rv, 32'h01);
      rd(ADDR_CTRL);
      chk(rv, CTL | 32'h8000);
      // adjust below thirty clears seconds, at or above adds a minute
      wr(ADDR_CTRL, CTL | 32'h4);
      rd(ADDR_SEC);
      chk(rv, 32'h0);
      rd(ADDR_MINHR);
      chk(rv, 32'h0);
      // a field is only rewritten once the count is idle
      i = 0;
      do begin
         rd(ADDR_CTRL);
         i++;
      end while (rv[CTRL_CBUSY] !== 1'b0 && i < 60);
      lim(i, 60);
      wr(ADDR_SEC, 32'h45);
      wr(ADDR_CTRL, CTL | 32'h4);
      rd(ADDR_MINHR);
      chk(rv, 32'h01);
      wrap_up();
   end
endmodule : bcdrtc_top_test
`default_nettype wire
